/* File: design/rthu_map.vh */
`ifndef RTHU_MAP_VH
`define RTHU_MAP_VH

// Clock and timebase
`define RTHU_CLK_HZ 40000000
`define RTHU_TICK_S 1
`define RTHU_SEC_PER_MIN 60
`define RTHU_SEC_PER_TEN 10

// Temperature source selection
`define RTHU_SRC_LOCAL 2'h0
`define RTHU_SRC_BUS 2'h1
`define RTHU_SRC_BOTH 2'h2
`define RTHU_SHARE_FULL 24'sd10

// Controller operating modes
`define RTHU_OPM_COMFORT 2'h0
`define RTHU_OPM_STANDBY 2'h1
`define RTHU_OPM_NIGHT 2'h2
`define RTHU_OPM_PROT 2'h3

// Protection override codes
`define RTHU_PRO_NONE 3'h0
`define RTHU_PRO_SEND_ON 3'h1
`define RTHU_PRO_SEND_OFF 3'h2
`define RTHU_PRO_ON_QUIET 3'h3
`define RTHU_PRO_OFF_QUIET 3'h4

// Humidity change steps in 0.1 %RH
`define RTHU_HDL_OFF 3'h0
`define RTHU_HDL_0P5 3'h1
`define RTHU_HDL_1 3'h2
`define RTHU_HDL_3 3'h3
`define RTHU_HDL_10 3'h4
`define RTHU_HSTEP_0P5 10'h005
`define RTHU_HSTEP_1 10'h00a
`define RTHU_HSTEP_3 10'h01e
`define RTHU_HSTEP_10 10'h064
`define RTHU_HUM_TX_DLY_S 4'ha

// Threshold settings
`define RTHU_THR_DEFAULT 10'h258
`define RTHU_EXT_NONE 2'h0
`define RTHU_EXT_ABS 2'h1
`define RTHU_EXT_PCT 2'h2
`define RTHU_EXT_TEACH 2'h3
`define RTHU_ACT_BOTH_LOW 4'h8

`endif

/* File: design/rthu_threshold.v */
`timescale 1ns/1ps
`default_nettype none
`include "rthu_map.vh"

module rthu_threshold (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Timebase and measurement
  input wire enable,
  input wire sec_tick,
  input wire ten_tick,
  input wire [9:0] hum,
  input wire hum_valid,
  // Configuration
  input wire [6:0] cfg_value,
  input wire [5:0] cfg_hyst,
  input wire [1:0] ext_sel,
  input wire [3:0] act_mode,
  input wire [3:0] on_dly,
  input wire [3:0] off_dly,
  input wire send_chg,
  input wire [6:0] cycle,
  // External setpoints
  input wire [15:0] ext_abs,
  input wire ext_abs_valid,
  input wire [7:0] ext_pct,
  input wire ext_pct_valid,
  input wire teach,
  // Protection mode
  input wire prot_active,
  input wire prot_apply,
  input wire [2:0] prot_code,
  // Threshold object
  output reg thr_obj,
  output reg thr_send
);

  reg [9:0] thr_reg;
  reg above_reg;
  reg state_reg;
  reg [11:0] dly_cnt_reg;
  reg [6:0] cyc_cnt_reg;
  wire [9:0] thr_eff;
  wire [9:0] hyst10;
  wire [9:0] lower;
  wire [9:0] up_lvl;
  wire freeze;
  wire [3:0] act;
  wire [11:0] dly_lim;

  // Delay code to seconds; 0 means no delay
  function [11:0] dly_sec;
    input [3:0] code;
    begin
      case (code)
        4'h0: dly_sec = 12'h000;
        4'h1: dly_sec = 12'h001;
        4'h2: dly_sec = 12'h003;
        4'h3: dly_sec = 12'h005;
        4'h4: dly_sec = 12'h00a;
        4'h5: dly_sec = 12'h00f;
        4'h6: dly_sec = 12'h01e;
        4'h7: dly_sec = 12'h03c;
        4'h8: dly_sec = 12'h0b4;
        4'h9: dly_sec = 12'h12c;
        4'ha: dly_sec = 12'h258;
        4'hb: dly_sec = 12'h384;
        4'hc: dly_sec = 12'h708;
        4'hd: dly_sec = 12'he10;
        default: dly_sec = 12'h000;
      endcase
    end
  endfunction

  // Mode to {up enable, up value, down enable, down value}
  function [3:0] act_map;
    input [3:0] mode;
    begin
      case (mode)
        4'h0: act_map = 4'b1110;
        4'h1: act_map = 4'b1011;
        4'h2: act_map = 4'b1011;
        4'h3: act_map = 4'b1110;
        4'h4: act_map = 4'b1100;
        4'h5: act_map = 4'b1000;
        4'h6: act_map = 4'b0011;
        4'h7: act_map = 4'b0010;
        4'h8: act_map = 4'b0010;
        4'h9: act_map = 4'b0011;
        4'ha: act_map = 4'b1000;
        4'hb: act_map = 4'b1100;
        default: act_map = 4'b0000;
      endcase
    end
  endfunction

  // Fixed setting unless a bus source is chosen
  assign thr_eff = (ext_sel == `RTHU_EXT_NONE) ? cfg_value * 10'd10 : thr_reg;
  assign hyst10 = cfg_hyst * 10'd10;
  assign lower = (thr_eff > hyst10) ? thr_eff - hyst10 : 10'h000;
  assign up_lvl = (act_mode >= `RTHU_ACT_BOTH_LOW) ? lower : thr_eff;
  assign freeze = prot_active && (prot_code != `RTHU_PRO_NONE);
  assign act = act_map(act_mode);
  assign dly_lim = state_reg ? dly_sec(on_dly) : dly_sec(off_dly);

  // External, percentage and taught setpoints
  always @(posedge clk) begin
    if (!reset_n) begin
      thr_reg <= `RTHU_THR_DEFAULT;
    end else if (ext_sel == `RTHU_EXT_ABS && ext_abs_valid) begin
      thr_reg <= (ext_abs > 16'h03e8) ? 10'h3e8 : ext_abs[9:0];
    end else if (ext_sel == `RTHU_EXT_PCT && ext_pct_valid) begin
      thr_reg <= (ext_pct > 8'h64) ? 10'h3e8 : ext_pct * 10'd10;
    end else if (ext_sel == `RTHU_EXT_TEACH && teach) begin
      thr_reg <= hum;
    end
  end

  // Comparison, delays, overrides and sending
  always @(posedge clk) begin
    if (!reset_n) begin
      above_reg <= 1'b0;
      state_reg <= 1'b0;
      thr_obj <= 1'b0;
      thr_send <= 1'b0;
      dly_cnt_reg <= 12'h000;
      cyc_cnt_reg <= 7'h00;
    end else begin
      thr_send <= 1'b0;
      if (!enable) begin
        dly_cnt_reg <= 12'h000;
      end else if (prot_apply) begin
        // Override wins over any pending delay
        case (prot_code)
          `RTHU_PRO_SEND_ON, `RTHU_PRO_ON_QUIET: begin
            state_reg <= 1'b1;
            thr_obj <= 1'b1;
            thr_send <= (prot_code == `RTHU_PRO_SEND_ON);
          end
          `RTHU_PRO_SEND_OFF, `RTHU_PRO_OFF_QUIET: begin
            state_reg <= 1'b0;
            thr_obj <= 1'b0;
            thr_send <= (prot_code == `RTHU_PRO_SEND_OFF);
          end
          default: begin
            thr_send <= 1'b0;
          end
        endcase
        dly_cnt_reg <= 12'h000;
      end else if (!freeze) begin
        // Previously stored sample (hum) compared against band edge for present state
        if (hum_valid) begin
          if (!above_reg && hum >= up_lvl) begin
            above_reg <= 1'b1;
            if (act[3]) begin
              state_reg <= act[2];
            end
          end else if (above_reg && hum < lower) begin
            above_reg <= 1'b0;
            if (act[1]) begin
              state_reg <= act[0];
            end
          end
        end
        // Object follows state after its direction's delay
        if (state_reg == thr_obj) begin
          dly_cnt_reg <= 12'h000;
        end else if (dly_cnt_reg >= dly_lim) begin
          thr_obj <= state_reg;
          thr_send <= send_chg;
          dly_cnt_reg <= 12'h000;
        end else if (sec_tick) begin
          dly_cnt_reg <= dly_cnt_reg + 12'h001;
        end
      end
      // Cyclic sending runs regardless of protection
      if (!enable || cycle == 7'h00) begin
        cyc_cnt_reg <= 7'h00;
      end else if (ten_tick) begin
        if (cyc_cnt_reg + 7'h01 >= cycle) begin
          cyc_cnt_reg <= 7'h00;
          thr_send <= 1'b1;
        end else begin
          cyc_cnt_reg <= cyc_cnt_reg + 7'h01;
        end
      end
    end
  end

endmodule // rthu_threshold

`default_nettype wire

/* File: design/rthu_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "rthu_map.vh"

module rthu_top #(
  parameter SEC_CYCLES = `RTHU_CLK_HZ * `RTHU_TICK_S
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Temperature configuration
  input wire [1:0] temp_src,
  input wire [3:0] local_share,
  input wire [7:0] calib_offset,
  input wire [7:0] poll_period,
  input wire [7:0] temp_delta,
  input wire [7:0] temp_cycle,
  // Humidity configuration
  input wire [2:0] hum_delta_sel,
  input wire [6:0] hum_cycle,
  input wire [1:0] thr_count,
  input wire [2:0] prot_heat,
  input wire [2:0] prot_cool,
  // Threshold 1 configuration
  input wire [6:0] thr1_value,
  input wire [5:0] thr1_hyst,
  input wire [1:0] thr1_ext_sel,
  input wire [3:0] thr1_act_mode,
  input wire [3:0] thr1_on_dly,
  input wire [3:0] thr1_off_dly,
  input wire thr1_send_chg,
  input wire [6:0] thr1_cycle,
  // Threshold 2 configuration
  input wire [6:0] thr2_value,
  input wire [5:0] thr2_hyst,
  input wire [1:0] thr2_ext_sel,
  input wire [3:0] thr2_act_mode,
  input wire [3:0] thr2_on_dly,
  input wire [3:0] thr2_off_dly,
  input wire thr2_send_chg,
  input wire [6:0] thr2_cycle,
  // Measurements and received objects
  input wire [15:0] local_temp,
  input wire local_temp_valid,
  input wire [15:0] rx_temp,
  input wire rx_temp_valid,
  input wire [9:0] humidity,
  input wire hum_valid,
  input wire [15:0] thr1_ext_abs,
  input wire thr1_ext_abs_valid,
  input wire [7:0] thr1_ext_pct,
  input wire thr1_ext_pct_valid,
  input wire thr1_teach,
  input wire [15:0] thr2_ext_abs,
  input wire thr2_ext_abs_valid,
  input wire [7:0] thr2_ext_pct,
  input wire thr2_ext_pct_valid,
  input wire thr2_teach,
  // Controller state
  input wire [1:0] op_mode,
  input wire cooling,
  // Outputs
  output reg ctrl_enable,
  output reg [15:0] room_temp,
  output reg room_temp_send,
  output reg rx_temp_request,
  output reg [9:0] hum_value,
  output reg hum_send,
  output wire thr1_obj,
  output wire thr1_send,
  output wire thr2_obj,
  output wire thr2_send
);

  reg [31:0] sec_cnt_reg;
  reg sec_tick_reg;
  reg [5:0] min_cnt_reg;
  reg min_tick_reg;
  reg [3:0] ten_cnt_reg;
  reg ten_tick_reg;
  reg [15:0] local_reg;
  reg [15:0] rx_cal_reg;
  reg rx_seen_reg;
  reg [15:0] temp_sent_reg;
  reg [7:0] temp_cyc_reg;
  reg [7:0] poll_cnt_reg;
  reg [9:0] hum_sent_reg;
  reg hum_pend_reg;
  reg [3:0] hum_dly_reg;
  reg [6:0] hum_cyc_reg;
  reg prot_reg;
  reg cool_reg;
  reg [9:0] hum_step;
  wire need_rx;
  wire signed [23:0] loc_w;
  wire signed [23:0] rx_w;
  wire signed [23:0] sh_w;
  wire signed [23:0] mix_w;
  wire [15:0] room_next;
  wire [16:0] tdiff;
  wire [15:0] tabs;
  wire [9:0] habs;
  wire prot;
  wire prot_apply;
  wire [2:0] prot_code;

  // One-second base, then ten-second and minute enables
  always @(posedge clk) begin
    if (!reset_n) begin
      sec_cnt_reg <= 32'h00000000;
      sec_tick_reg <= 1'b0;
      ten_cnt_reg <= 4'h0;
      ten_tick_reg <= 1'b0;
      min_cnt_reg <= 6'h00;
      min_tick_reg <= 1'b0;
    end else begin
      sec_tick_reg <= 1'b0;
      ten_tick_reg <= 1'b0;
      min_tick_reg <= 1'b0;
      if (sec_cnt_reg >= SEC_CYCLES - 1) begin
        sec_cnt_reg <= 32'h00000000;
        sec_tick_reg <= 1'b1;
      end else begin
        sec_cnt_reg <= sec_cnt_reg + 32'h00000001;
      end
      if (sec_tick_reg) begin
        if (ten_cnt_reg == `RTHU_SEC_PER_TEN - 1) begin
          ten_cnt_reg <= 4'h0;
          ten_tick_reg <= 1'b1;
        end else begin
          ten_cnt_reg <= ten_cnt_reg + 4'h1;
        end
        if (min_cnt_reg == `RTHU_SEC_PER_MIN - 1) begin
          min_cnt_reg <= 6'h00;
          min_tick_reg <= 1'b1;
        end else begin
          min_cnt_reg <= min_cnt_reg + 6'h01;
        end
      end
    end
  end

  // Source mixing; division by ten keeps the share exact
  assign need_rx = (temp_src != `RTHU_SRC_LOCAL);
  assign loc_w = {{8{local_reg[15]}}, local_reg};
  assign rx_w = {{8{rx_cal_reg[15]}}, rx_cal_reg};
  assign sh_w = {20'h00000, local_share};
  assign mix_w = (loc_w * sh_w + rx_w * (`RTHU_SHARE_FULL - sh_w)) / `RTHU_SHARE_FULL;
  assign room_next = (temp_src == `RTHU_SRC_LOCAL) ? local_reg :
                     (temp_src == `RTHU_SRC_BUS) ? rx_cal_reg : mix_w[15:0];
  assign tdiff = {room_temp[15], room_temp} - {temp_sent_reg[15], temp_sent_reg};
  assign tabs = tdiff[16] ? 16'h0000 - tdiff[15:0] : tdiff[15:0];

  // Temperature capture, control release, room value, mode history
  always @(posedge clk) begin
    if (!reset_n) begin
      prot_reg <= 1'b0;
      cool_reg <= 1'b0;
      local_reg <= 16'h0000;
      rx_cal_reg <= 16'h0000;
      rx_seen_reg <= 1'b0;
      ctrl_enable <= 1'b0;
      room_temp <= 16'h0000;
    end else begin
      if (local_temp_valid) begin
        local_reg <= local_temp;
      end
      if (rx_temp_valid) begin
        rx_cal_reg <= rx_temp + {{8{calib_offset[7]}}, calib_offset};
        rx_seen_reg <= 1'b1;
      end
      ctrl_enable <= !need_rx || rx_seen_reg;
      room_temp <= room_next;
      prot_reg <= prot;
      cool_reg <= cooling;
    end
  end

  // Change and cyclic sending of room temperature, polling
  always @(posedge clk) begin
    if (!reset_n) begin
      temp_sent_reg <= 16'h0000;
      room_temp_send <= 1'b0;
      temp_cyc_reg <= 8'h00;
      rx_temp_request <= 1'b0;
      poll_cnt_reg <= 8'h00;
    end else begin
      room_temp_send <= 1'b0;
      rx_temp_request <= 1'b0;
      // No room temperature goes out until the value is trustworthy
      if (ctrl_enable && temp_delta != 8'h00 && tabs >= {8'h00, temp_delta}) begin
        room_temp_send <= 1'b1;
        temp_sent_reg <= room_temp;
      end
      if (temp_cycle == 8'h00) begin
        temp_cyc_reg <= 8'h00;
      end else if (min_tick_reg) begin
        if (temp_cyc_reg + 8'h01 >= temp_cycle) begin
          temp_cyc_reg <= 8'h00;
          if (ctrl_enable) begin
            room_temp_send <= 1'b1;
            temp_sent_reg <= room_temp;
          end
        end else begin
          temp_cyc_reg <= temp_cyc_reg + 8'h01;
        end
      end
      // Zero period leaves the remote sensor to send on its own
      if (!need_rx || poll_period == 8'h00) begin
        poll_cnt_reg <= 8'h00;
      end else if (min_tick_reg) begin
        if (poll_cnt_reg + 8'h01 >= poll_period) begin
          poll_cnt_reg <= 8'h00;
          rx_temp_request <= 1'b1;
        end else begin
          poll_cnt_reg <= poll_cnt_reg + 8'h01;
        end
      end
    end
  end

  // Humidity change step in 0.1 percent RH
  always @* begin
    case (hum_delta_sel)
      `RTHU_HDL_0P5: hum_step = `RTHU_HSTEP_0P5;
      `RTHU_HDL_1: hum_step = `RTHU_HSTEP_1;
      `RTHU_HDL_3: hum_step = `RTHU_HSTEP_3;
      `RTHU_HDL_10: hum_step = `RTHU_HSTEP_10;
      default: hum_step = 10'h000;
    endcase
  end
  assign habs = (hum_value > hum_sent_reg) ? hum_value - hum_sent_reg : hum_sent_reg - hum_value;

  // Humidity sending; delay caps bus load, latest value goes out
  always @(posedge clk) begin
    if (!reset_n) begin
      hum_value <= 10'h000;
      hum_sent_reg <= 10'h000;
      hum_pend_reg <= 1'b0;
      hum_dly_reg <= 4'h0;
      hum_cyc_reg <= 7'h00;
      hum_send <= 1'b0;
    end else begin
      hum_send <= 1'b0;
      if (hum_valid) begin
        hum_value <= humidity;
      end
      if (hum_step == 10'h000) begin
        hum_pend_reg <= 1'b0;
        hum_dly_reg <= 4'h0;
      end else if (!hum_pend_reg) begin
        if (habs >= hum_step) begin
          hum_pend_reg <= 1'b1;
          hum_dly_reg <= 4'h0;
        end
      end else if (sec_tick_reg) begin
        if (hum_dly_reg + 4'h1 >= `RTHU_HUM_TX_DLY_S) begin
          hum_pend_reg <= 1'b0;
          hum_send <= 1'b1;
          hum_sent_reg <= hum_value;
        end else begin
          hum_dly_reg <= hum_dly_reg + 4'h1;
        end
      end
      if (hum_cycle == 7'h00) begin
        hum_cyc_reg <= 7'h00;
      end else if (ten_tick_reg) begin
        if (hum_cyc_reg + 7'h01 >= hum_cycle) begin
          hum_cyc_reg <= 7'h00;
          hum_send <= 1'b1;
          hum_sent_reg <= hum_value;
        end else begin
          hum_cyc_reg <= hum_cyc_reg + 7'h01;
        end
      end
    end
  end

  // Protection entry and heat/cool swap trigger the override
  assign prot = (op_mode == `RTHU_OPM_PROT);
  assign prot_code = cooling ? prot_cool : prot_heat;
  assign prot_apply = prot && (!prot_reg || cooling != cool_reg);

  // Two channels, enabled by the configured count
  rthu_threshold u_thr1 (
    .clk(clk), .reset_n(reset_n),
    .enable(thr_count != 2'h0),
    .sec_tick(sec_tick_reg), .ten_tick(ten_tick_reg), .hum(hum_value), .hum_valid(hum_valid),
    .cfg_value(thr1_value), .cfg_hyst(thr1_hyst), .ext_sel(thr1_ext_sel),
    .act_mode(thr1_act_mode), .on_dly(thr1_on_dly), .off_dly(thr1_off_dly),
    .send_chg(thr1_send_chg), .cycle(thr1_cycle),
    .ext_abs(thr1_ext_abs), .ext_abs_valid(thr1_ext_abs_valid),
    .ext_pct(thr1_ext_pct), .ext_pct_valid(thr1_ext_pct_valid), .teach(thr1_teach),
    .prot_active(prot), .prot_apply(prot_apply), .prot_code(prot_code),
    .thr_obj(thr1_obj), .thr_send(thr1_send)
  );

  rthu_threshold u_thr2 (
    .clk(clk), .reset_n(reset_n),
    .enable(thr_count >= 2'h2),
    .sec_tick(sec_tick_reg), .ten_tick(ten_tick_reg), .hum(hum_value), .hum_valid(hum_valid),
    .cfg_value(thr2_value), .cfg_hyst(thr2_hyst), .ext_sel(thr2_ext_sel),
    .act_mode(thr2_act_mode), .on_dly(thr2_on_dly), .off_dly(thr2_off_dly),
    .send_chg(thr2_send_chg), .cycle(thr2_cycle),
    .ext_abs(thr2_ext_abs), .ext_abs_valid(thr2_ext_abs_valid),
    .ext_pct(thr2_ext_pct), .ext_pct_valid(thr2_ext_pct_valid), .teach(thr2_teach),
    .prot_active(prot), .prot_apply(prot_apply), .prot_code(prot_code),
    .thr_obj(thr2_obj), .thr_send(thr2_send)
  );

endmodule // rthu_top

`default_nettype wire

/* File: verification/rthu_remote_sensor.sv */
`timescale 1ns/1ps
`default_nettype none

module rthu_remote_sensor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Request from the block and own-initiative enable
  input wire logic rx_temp_request,
  input wire logic self_send,
  input wire logic [15:0] value,
  // Received temperature object
  output logic [15:0] rx_temp,
  output logic rx_temp_valid
);
  logic [5:0] cnt_reg;
  logic [1:0] dly_reg;

  // Answer a poll three cycles late; idle bus shows the inverse, never a stale value
  always @(posedge clk) begin
    rx_temp_valid <= 1'b0;
    rx_temp <= ~value;
    cnt_reg <= reset_n ? cnt_reg + 6'h01 : 6'h00;
    dly_reg <= !reset_n ? 2'h0 : rx_temp_request ? 2'h3 : (dly_reg != 2'h0 ? dly_reg - 2'h1 : 2'h0);
    if (reset_n && (dly_reg == 2'h1 || (self_send && cnt_reg == 6'h3f))) begin
      rx_temp_valid <= 1'b1;
      rx_temp <= value;
    end
  end
endmodule // rthu_remote_sensor

`default_nettype wire

/* File: verification/rthu_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rthu_map.vh"

module rthu_top_bench;
  logic clk, reset_n, local_temp_valid, hum_valid, cooling, thr1_send_chg, thr2_send_chg, self_send;
  logic thr1_ext_abs_valid, thr1_ext_pct_valid, thr1_teach, thr2_ext_abs_valid, thr2_ext_pct_valid, thr2_teach;
  logic [1:0] temp_src, thr_count, thr1_ext_sel, thr2_ext_sel, op_mode;
  logic [2:0] hum_delta_sel, prot_heat, prot_cool;
  logic [3:0] local_share, thr1_act_mode, thr1_on_dly, thr1_off_dly, thr2_act_mode, thr2_on_dly, thr2_off_dly;
  logic [5:0] thr1_hyst, thr2_hyst;
  logic [6:0] hum_cycle, thr1_value, thr1_cycle, thr2_value, thr2_cycle;
  logic [7:0] calib_offset, poll_period, temp_delta, temp_cycle, thr1_ext_pct, thr2_ext_pct;
  logic [9:0] humidity;
  logic [15:0] local_temp, thr1_ext_abs, thr2_ext_abs, rx_value;
  wire ctrl_enable, room_temp_send, rx_temp_request, hum_send, thr1_obj, thr1_send, thr2_obj, thr2_send;
  wire rx_temp_valid;
  wire [9:0] hum_value;
  wire [15:0] room_temp, rx_temp;
  int mismatches = 0;
  int samples_checked = 0;
  int n, rsends, tsends;

  // Short second so that minute periods fit the run
  rthu_top #(.SEC_CYCLES(10)) dut (.clk, .reset_n, .temp_src, .local_share, .calib_offset, .poll_period,
    .temp_delta, .temp_cycle, .hum_delta_sel, .hum_cycle, .thr_count, .prot_heat, .prot_cool, .thr1_value,
    .thr1_hyst, .thr1_ext_sel, .thr1_act_mode, .thr1_on_dly, .thr1_off_dly, .thr1_send_chg, .thr1_cycle,
    .thr2_value, .thr2_hyst, .thr2_ext_sel, .thr2_act_mode, .thr2_on_dly, .thr2_off_dly, .thr2_send_chg,
    .thr2_cycle, .local_temp, .local_temp_valid, .rx_temp, .rx_temp_valid, .humidity, .hum_valid,
    .thr1_ext_abs, .thr1_ext_abs_valid, .thr1_ext_pct, .thr1_ext_pct_valid, .thr1_teach, .thr2_ext_abs,
    .thr2_ext_abs_valid, .thr2_ext_pct, .thr2_ext_pct_valid, .thr2_teach, .op_mode, .cooling, .ctrl_enable,
    .room_temp, .room_temp_send, .rx_temp_request, .hum_value, .hum_send, .thr1_obj, .thr1_send, .thr2_obj,
    .thr2_send);
  rthu_remote_sensor partner (.clk, .reset_n, .rx_temp_request, .self_send, .value(rx_value), .rx_temp,
    .rx_temp_valid);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Count send pulses; a pulse stands only one cycle
  always @(posedge clk) begin
    rsends <= !reset_n ? 0 : rsends + int'(room_temp_send);
    tsends <= !reset_n ? 0 : tsends + int'(thr1_send);
  end

  task results;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task do_reset;
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  // Bounded wait: 0 control, 1 request, 2 humidity send, 3 room send
  task wait_on(input int sel, input int lim);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge clk);
      #1;
      n++;
      hit = sel == 0 ? ctrl_enable === 1'b1 : sel == 1 ? rx_temp_request === 1'b1 :
            sel == 2 ? hum_send === 1'b1 : room_temp_send === 1'b1;
    end
    if (!hit) begin
      mismatches++;
      $display("Error %0t: wait %0d timed out", $time, sel);
      results;
    end
  endtask

  task local_in(input logic [15:0] v);
    @(posedge clk);
    local_temp <= v;
    local_temp_valid <= 1'b1;
    @(posedge clk);
    local_temp_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Two samples per level: evaluation lags one sample
  task hum_in(input logic [9:0] v);
    repeat (2) begin
      @(posedge clk);
      humidity <= v;
      hum_valid <= 1'b1;
      @(posedge clk);
      hum_valid <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  initial begin
    {reset_n, local_temp_valid, hum_valid, cooling, thr1_send_chg, thr2_send_chg, self_send, thr1_ext_abs_valid,
     thr1_ext_pct_valid, thr1_teach, thr2_ext_abs_valid, thr2_ext_pct_valid, thr2_teach, temp_src, thr_count,
     thr1_ext_sel, thr2_ext_sel, op_mode, hum_delta_sel, prot_heat, prot_cool, local_share, thr1_act_mode,
     thr1_on_dly, thr1_off_dly, thr2_act_mode, thr2_on_dly, thr2_off_dly, thr1_hyst, thr2_hyst, hum_cycle,
     thr1_value, thr1_cycle, thr2_value, thr2_cycle, calib_offset, poll_period, temp_delta, temp_cycle,
     thr1_ext_pct, thr2_ext_pct, humidity, local_temp, thr1_ext_abs, thr2_ext_abs} = '0;
    thr1_value = 7'h3c;
    thr1_hyst = 6'h03;
    thr1_send_chg = 1'b1;
    rx_value = 16'h00c8;
    temp_delta = 8'h03;
    // Local source: sub-delta step must not send
    do_reset;
    repeat (3) @(posedge clk);
    check_val(16'(ctrl_enable), 16'h0001);
    local_in(16'h00d7);
    local_in(16'h00d8);
    local_in(16'h00dc);
    check_val(room_temp, 16'h00dc);
    check_val(16'(rsends), 16'h0002);
    // Bus source with negative offset, polled once a minute
    temp_src <= `RTHU_SRC_BUS;
    calib_offset <= 8'hfb;
    poll_period <= 8'h01;
    temp_cycle <= 8'h01;
    do_reset;
    repeat (100) @(posedge clk);
    check_val(16'(ctrl_enable), 16'h0000);
    wait_on(1, 800);
    check_val(16'(n > 400), 16'h0001);
    wait_on(0, 20);
    repeat (2) @(posedge clk);
    check_val(room_temp, rx_value + {{8{calib_offset[7]}}, calib_offset});
    // First cyclic tick falls before the telegram and is withheld
    wait_on(3, 700);
    check_val(16'(n > 500), 16'h0001);
    @(posedge clk);
    // Combined source, partner sends unprompted
    temp_src <= `RTHU_SRC_BOTH;
    local_share <= 4'h3;
    calib_offset <= 8'h00;
    poll_period <= 8'h00;
    temp_cycle <= 8'h00;
    self_send <= 1'b1;
    rx_value <= 16'h012c;
    do_reset;
    local_in(16'h0064);
    wait_on(0, 100);
    repeat (3) @(posedge clk);
    check_val(room_temp, 16'((100 * 3 + 300 * 7) / 10));
    // Humidity change send after the transmission delay
    temp_src <= `RTHU_SRC_LOCAL;
    self_send <= 1'b0;
    hum_delta_sel <= `RTHU_HDL_3;
    do_reset;
    hum_in(10'h1f4);
    wait_on(2, 150);
    check_val(16'(n >= 80), 16'h0001);
    check_val(16'(hum_value), 16'h01f4);
    @(posedge clk);
    // Threshold at 60 %RH, hysteresis 3, then protection overrides
    hum_delta_sel <= `RTHU_HDL_OFF;
    thr_count <= 2'h1;
    temp_delta <= 8'h00;
    prot_heat <= `RTHU_PRO_ON_QUIET;
    prot_cool <= `RTHU_PRO_SEND_OFF;
    do_reset;
    hum_in(10'h28a);
    check_val(16'(thr1_obj), 16'h0001);
    check_val(16'(thr2_obj), 16'h0000);
    hum_in(10'h244);
    check_val(16'(thr1_obj), 16'h0001);
    // One-second switch-off delay holds the object past the crossing
    thr1_off_dly <= 4'h1;
    hum_in(10'h230);
    check_val(16'(thr1_obj), 16'h0001);
    repeat (4) @(posedge clk);
    check_val(16'(thr1_obj), 16'h0000);
    check_val(16'(tsends), 16'h0002);
    op_mode <= `RTHU_OPM_PROT;
    repeat (4) @(posedge clk);
    check_val(16'(thr1_obj), 16'h0001);
    check_val(16'(tsends), 16'h0002);
    hum_in(10'h230);
    check_val(16'(thr1_obj), 16'h0001);
    cooling <= 1'b1;
    repeat (4) @(posedge clk);
    check_val(16'(thr1_obj), 16'h0000);
    check_val(16'(tsends), 16'h0003);
    op_mode <= `RTHU_OPM_COMFORT;
    hum_in(10'h28a);
    check_val(16'(thr1_obj), 16'h0001);
    check_val(16'(tsends), 16'h0004);
    results;
  end
endmodule // rthu_top_bench

`default_nettype wire

/* File: verification/rthu_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rthu_map.vh"

module rthu_top_monitor #(
  parameter SEC_CYCLES = 40000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Configuration
  input wire logic [1:0] temp_src,
  input wire logic [7:0] poll_period,
  input wire logic [7:0] temp_delta,
  input wire logic [7:0] temp_cycle,
  input wire logic [2:0] hum_delta_sel,
  input wire logic [6:0] hum_cycle,
  input wire logic [1:0] thr_count,
  input wire logic [2:0] prot_heat,
  input wire logic [2:0] prot_cool,
  input wire logic [6:0] thr1_cycle,
  // Measurements and controller state
  input wire logic [9:0] humidity,
  input wire logic hum_valid,
  input wire logic rx_temp_valid,
  input wire logic [1:0] op_mode,
  input wire logic cooling,
  // Outputs
  input wire logic ctrl_enable,
  input wire logic room_temp_send,
  input wire logic rx_temp_request,
  input wire logic [9:0] hum_value,
  input wire logic hum_send,
  input wire logic thr1_obj,
  input wire logic thr1_send
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Protection entered in heating, or heating swapped to cooling inside protection
  sequence prot_entry;
    op_mode == `RTHU_OPM_PROT && $past(op_mode) != `RTHU_OPM_PROT && !cooling && thr_count != 2'h0 && thr1_cycle == 7'h00;
  endsequence
  sequence prot_swap;
    op_mode == `RTHU_OPM_PROT && $past(op_mode) == `RTHU_OPM_PROT && $rose(cooling) && thr_count != 2'h0;
  endsequence

  chk_local_start: assert property ($rose(reset_n) && temp_src == `RTHU_SRC_LOCAL |-> ##[1:3] ctrl_enable)
    else $error("control did not start with local source");
  chk_bus_wait: assert property ($rose(ctrl_enable) && temp_src != `RTHU_SRC_LOCAL
    |-> $past(rx_temp_valid) || $past(rx_temp_valid, 2) || $past(rx_temp_valid, 3))
    else $error("control started without a telegram");
  chk_poll_off: assert property (poll_period == 8'h00 && $past(poll_period) == 8'h00 |-> !rx_temp_request)
    else $error("request sent with polling off");
  chk_room_quiet: assert property (temp_delta == 8'h00 && temp_cycle == 8'h00 |-> !room_temp_send)
    else $error("room temperature sent while disabled");
  chk_hum_sample: assert property (hum_valid |=> hum_value == $past(humidity))
    else $error("humidity sample not taken");
  chk_hum_quiet: assert property (hum_delta_sel == `RTHU_HDL_OFF && hum_cycle == 7'h00 |-> !hum_send)
    else $error("humidity sent while disabled");
  chk_quiet_set: assert property (prot_entry ##0 prot_heat == `RTHU_PRO_ON_QUIET
    |-> ##1 !thr1_send ##1 (thr1_obj && !thr1_send) ##1 !thr1_send)
    else $error("quiet override wrong");
  chk_swap_send: assert property (prot_swap ##0 prot_cool == `RTHU_PRO_SEND_OFF |-> ##[1:3] (thr1_send && !thr1_obj))
    else $error("swap override not sent");
endmodule // rthu_top_monitor

bind rthu_top rthu_top_monitor #(.SEC_CYCLES(SEC_CYCLES)) u_monitor (.clk, .reset_n, .temp_src, .poll_period,
  .temp_delta, .temp_cycle, .hum_delta_sel, .hum_cycle, .thr_count, .prot_heat, .prot_cool, .thr1_cycle,
  .humidity, .hum_valid, .rx_temp_valid, .op_mode, .cooling, .ctrl_enable, .room_temp_send,
  .rx_temp_request, .hum_value, .hum_send, .thr1_obj, .thr1_send);

`default_nettype wire
